// >>> src/pitd_pkg.sv
package pitd_pkg;
    typedef logic [10:0] pitd_code_t;
    localparam int         NUM_TERM      = 7;
    localparam int         CLK_PERIOD_NS = 20;
    localparam int         DEB_TIME_NS   = 20000;
    localparam int         DEB_CYC       = (DEB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam pitd_code_t NEG_OFFSET    = 11'h3E8;
    // command base codes
    localparam pitd_code_t CMD_SS1   = 11'h000;
    localparam pitd_code_t CMD_SS2   = 11'h001;
    localparam pitd_code_t CMD_SS4   = 11'h002;
    localparam pitd_code_t CMD_HOLD  = 11'h006;
    localparam pitd_code_t CMD_COAST = 11'h007;
    localparam pitd_code_t CMD_ARST  = 11'h008;
    localparam pitd_code_t CMD_TRIP  = 11'h009;
    localparam pitd_code_t CMD_FSEL  = 11'h00B;
    localparam pitd_code_t CMD_LINK  = 11'h018;
    localparam pitd_code_t CMD_STOP  = 11'h01E;
    localparam pitd_code_t CMD_PCLR  = 11'h032;
    localparam pitd_code_t CMD_PUMP1 = 11'h033;
    localparam pitd_code_t CMD_RSET  = 11'h057;
    localparam pitd_code_t CMD_SECOND_SET_FORWARD  = 11'h058;
    localparam pitd_code_t CMD_SECOND_SET_BACKWARD  = 11'h059;
    localparam pitd_code_t CMD_FWD   = 11'h062;
    localparam pitd_code_t CMD_REV   = 11'h063;
    localparam int         TERM_FWD  = 5;
    localparam int         TERM_REV  = 6;
    // apb map
    localparam logic [7:0] OFS_ASG0   = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam pitd_code_t ASG_RST [NUM_TERM] = '{CMD_SS1, CMD_SS2, CMD_SS4, CMD_COAST, CMD_ARST, CMD_FWD, CMD_REV};

    // base codes the decoder knows at all
    function automatic logic code_known(input pitd_code_t b);
        case (b)
            11'h000, 11'h001, 11'h002, 11'h006, 11'h007, 11'h008, 11'h009, 11'h00B, 11'h00D, 11'h00F,
            11'h010, 11'h011, 11'h012, 11'h013, 11'h014, 11'h015, 11'h016, 11'h018, 11'h019, 11'h01A,
            11'h01E, 11'h021, 11'h022, 11'h023, 11'h026, 11'h027, 11'h028, 11'h029, 11'h032, 11'h033,
            11'h034, 11'h035, 11'h036, 11'h057, 11'h058, 11'h059, 11'h062, 11'h063: code_known = 1'b1;
            default: code_known = 1'b0;
        endcase
    endfunction : code_known

    // commands with no inverted form
    function automatic logic code_no_inv(input pitd_code_t b);
        case (b)
            11'h00D, 11'h00F, 11'h010, 11'h027, 11'h028, 11'h029, 11'h058, 11'h059, 11'h062, 11'h063: begin
                code_no_inv = 1'b1;
            end
            default: code_no_inv = 1'b0;
        endcase
    endfunction : code_no_inv
endpackage : pitd_pkg

// >>> src/pitd_top.sv
`timescale 1ns/1ps
module pitd_top
    import pitd_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST,
    input  wire logic        GENERAL_INPUT_1,
    input  wire logic        GENERAL_INPUT_2,
    input  wire logic        GENERAL_INPUT_3,
    input  wire logic        GENERAL_INPUT_4,
    input  wire logic        GENERAL_INPUT_5,
    input  wire logic        RUN_FORWARD,
    input  wire logic        RUN_BACKWARD,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic      [2:0]  PRESET_INDEX,
    output logic             FREQ_SOURCE_SEL,
    output logic             RUN_FWD_CMD,
    output logic             RUN_REV_CMD,
    output logic             OUTPUT_CUT,
    output logic             FORCE_STOP,
    output logic             FAULT_RELAY,
    output logic             EXT_ALARM_SHOW,
    output logic [3:0]       PUMP_MOTOR_ON,
    output logic             PUMP_TIMER_CLEAR,
    output logic             RUN_SET_SELECT,
    output logic             COMMS_LINK_ON
);
    logic [NUM_TERM-1:0] pin_in;
    logic [NUM_TERM-1:0] sync1_r;
    logic [NUM_TERM-1:0] sync2_r;
    logic [NUM_TERM-1:0] deb_r;
    logic [NUM_TERM-1:0] act;
    pitd_code_t          asg_r  [NUM_TERM];
    pitd_code_t          base   [NUM_TERM];
    logic                ack_r;
    logic                hold_on, hold_asg, fwd_lvl, rev_lvl, arst_on, arst_d_r, trip_on;
    logic                run_fwd_latch_r, run_rev_latch_r, trip_r, disp_r;
    logic                arst_rise, arst_fall;

    assign pin_in = {RUN_BACKWARD, RUN_FORWARD, GENERAL_INPUT_5, GENERAL_INPUT_4,
                     GENERAL_INPUT_3, GENERAL_INPUT_2, GENERAL_INPUT_1};

    // any terminal with this base code and asserted
    function automatic logic cmd_hit(input logic [NUM_TERM-1:0] a, input pitd_code_t b [NUM_TERM],
                                     input pitd_code_t c);
        cmd_hit = 1'b0;
        for (int k = 0; k < NUM_TERM; k++) begin
            if (b[k] == c && a[k]) begin
                cmd_hit = 1'b1;
            end
        end
    endfunction : cmd_hit

    // two-flop synchroniser
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // per-terminal debounce, polarity and base decode
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TERM; gi++) begin : g_term
            logic [15:0] cnt_r;
            logic        deb_bit_r;
            logic        neg, fs;
            // one process per terminal owns its own debounced bit
            always_ff @(posedge CLK_SYS) begin
                if (RST) begin
                    cnt_r     <= '0;
                    deb_bit_r <= 1'b0;
                end else if (sync2_r[gi] == deb_bit_r) begin
                    cnt_r <= '0;
                end else if (cnt_r == 16'(DEB_CYC - 1)) begin
                    cnt_r     <= '0;
                    deb_bit_r <= sync2_r[gi];
                end else begin
                    cnt_r <= cnt_r + 16'h0001;
                end
            end
            assign deb_r[gi] = deb_bit_r;
            assign neg      = (asg_r[gi] >= NEG_OFFSET);
            assign base[gi] = neg ? asg_r[gi] - NEG_OFFSET : asg_r[gi];
            assign fs       = (base[gi] == CMD_TRIP) || (base[gi] == CMD_STOP);
            assign act[gi]  = deb_r[gi] ^ neg ^ fs;
        end
    endgenerate

    // apb slave: one wait state, then pready
    logic       wr_ok, sel_asg, sel_stat, acc;
    logic [2:0] widx;
    pitd_code_t wcode, wbase;
    assign acc      = PSEL && PENABLE;
    assign widx     = PADDR[4:2];
    assign sel_asg  = (PADDR[1:0] == 2'b00) && (PADDR < OFS_STATUS);
    assign sel_stat = (PADDR == OFS_STATUS);
    assign wcode    = PWDATA[10:0];
    assign wbase    = (wcode >= NEG_OFFSET) ? wcode - NEG_OFFSET : wcode;
    assign wr_ok    = sel_asg && (PWDATA[31:11] == '0) && code_known(wbase)
                      && !((wcode >= NEG_OFFSET) && code_no_inv(wbase))
                      && !(((wbase == CMD_FWD) || (wbase == CMD_REV))
                           && (widx != 3'(TERM_FWD)) && (widx != 3'(TERM_REV)));
    assign PREADY   = ack_r;
    assign PSLVERR  = ack_r && (PWRITE ? !wr_ok : !(sel_asg || sel_stat));

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ack_r  <= 1'b0;
            PRDATA <= 32'h0000_0000;
        end else begin
            ack_r <= acc && !ack_r;
            if (acc && !ack_r && !PWRITE) begin
                if (sel_asg) begin
                    PRDATA <= {21'h00_0000, asg_r[widx]};
                end else if (sel_stat) begin
                    PRDATA <= {16'h0000, 1'b0, act, 1'b0, deb_r};
                end else begin
                    PRDATA <= 32'h0000_0000;
                end
            end
        end
    end

    // assignment registers
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            for (int k = 0; k < NUM_TERM; k++) begin
                asg_r[k] <= ASG_RST[k];
            end
        end else if (ack_r && PWRITE && wr_ok) begin
            asg_r[widx] <= wcode;
        end
    end

    // command levels; unassigned commands stay off
    assign hold_asg  = (base[0] == CMD_HOLD) || (base[1] == CMD_HOLD) || (base[2] == CMD_HOLD)
                       || (base[3] == CMD_HOLD) || (base[4] == CMD_HOLD) || (base[5] == CMD_HOLD)
                       || (base[6] == CMD_HOLD);
    assign hold_on   = cmd_hit(act, base, CMD_HOLD);
    assign fwd_lvl   = cmd_hit(act, base, CMD_RSET) ? cmd_hit(act, base, CMD_SECOND_SET_FORWARD)
                                                    : cmd_hit(act, base, CMD_FWD);
    assign rev_lvl   = cmd_hit(act, base, CMD_RSET) ? cmd_hit(act, base, CMD_SECOND_SET_BACKWARD)
                                                    : cmd_hit(act, base, CMD_REV);
    assign arst_on   = cmd_hit(act, base, CMD_ARST);
    assign trip_on   = cmd_hit(act, base, CMD_TRIP);
    assign arst_rise = arst_on && !arst_d_r;
    assign arst_fall = !arst_on && arst_d_r;

    // three-wire self-hold of the first run edge
    logic fwd_d_r, rev_d_r;
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            fwd_d_r         <= 1'b0;
            rev_d_r         <= 1'b0;
            run_fwd_latch_r <= 1'b0;
            run_rev_latch_r <= 1'b0;
        end else begin
            fwd_d_r <= fwd_lvl;
            rev_d_r <= rev_lvl;
            if (!hold_on) begin
                run_fwd_latch_r <= 1'b0;
                run_rev_latch_r <= 1'b0;
            end else if (!run_fwd_latch_r && !run_rev_latch_r) begin
                run_fwd_latch_r <= fwd_lvl && !fwd_d_r;
                run_rev_latch_r <= rev_lvl && !rev_d_r && !(fwd_lvl && !fwd_d_r);
            end
        end
    end

    // trip latch, fault relay, alarm display; set wins over clear
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            arst_d_r    <= 1'b0;
            trip_r      <= 1'b0;
            disp_r      <= 1'b0;
            FAULT_RELAY <= 1'b0;
        end else begin
            arst_d_r <= arst_on;
            if (trip_on) begin
                trip_r      <= 1'b1;
                disp_r      <= 1'b1;
                FAULT_RELAY <= 1'b1;
            end else begin
                if (arst_rise) begin
                    FAULT_RELAY <= 1'b0;
                end
                if (arst_fall) begin
                    trip_r <= 1'b0;
                    disp_r <= 1'b0;
                end
            end
        end
    end
    assign EXT_ALARM_SHOW = disp_r;

    // registered command outputs
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            PRESET_INDEX     <= 3'h0;
            FREQ_SOURCE_SEL  <= 1'b0;
            RUN_FWD_CMD      <= 1'b0;
            RUN_REV_CMD      <= 1'b0;
            OUTPUT_CUT       <= 1'b0;
            FORCE_STOP       <= 1'b0;
            PUMP_MOTOR_ON    <= 4'h0;
            PUMP_TIMER_CLEAR <= 1'b0;
            RUN_SET_SELECT   <= 1'b0;
            COMMS_LINK_ON    <= 1'b0;
        end else begin
            PRESET_INDEX    <= {cmd_hit(act, base, CMD_SS4), cmd_hit(act, base, CMD_SS2),
                                cmd_hit(act, base, CMD_SS1)};
            FREQ_SOURCE_SEL <= cmd_hit(act, base, CMD_FSEL);
            RUN_FWD_CMD     <= hold_asg ? run_fwd_latch_r : fwd_lvl;
            RUN_REV_CMD     <= hold_asg ? run_rev_latch_r : rev_lvl;
            OUTPUT_CUT      <= cmd_hit(act, base, CMD_COAST) || trip_on || trip_r;
            FORCE_STOP      <= cmd_hit(act, base, CMD_STOP);
            for (int p = 0; p < 4; p++) begin
                PUMP_MOTOR_ON[p] <= cmd_hit(act, base, CMD_PUMP1 + 11'(p));
            end
            PUMP_TIMER_CLEAR <= cmd_hit(act, base, CMD_PCLR);
            RUN_SET_SELECT   <= cmd_hit(act, base, CMD_RSET);
            COMMS_LINK_ON    <= cmd_hit(act, base, CMD_LINK);
        end
    end

    // checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);

    sequence s_arst_rise;
        !arst_on ##1 arst_on;
    endsequence
    sequence s_arst_fall;
        arst_on ##1 !arst_on;
    endsequence

    property p_coast;
        (cmd_hit(act, base, CMD_COAST) && !trip_on && !FAULT_RELAY) |=> OUTPUT_CUT && !FAULT_RELAY;
    endproperty
    a_coast: assert property (p_coast) else $error("coast did not cut output");

    property p_trip_set;
        trip_on |=> FAULT_RELAY && EXT_ALARM_SHOW && OUTPUT_CUT;
    endproperty
    a_trip_set: assert property (p_trip_set) else $error("trip did not raise alarm");

    property p_trip_hold;
        (trip_r && !trip_on) ##1 !$past(arst_fall) |-> trip_r;
    endproperty
    a_trip_hold: assert property (p_trip_hold) else $error("trip latch dropped without reset");

    property p_arst_relay;
        (s_arst_rise ##0 !trip_on) |=> !FAULT_RELAY;
    endproperty
    a_arst_relay: assert property (p_arst_relay) else $error("reset did not clear relay");

    property p_arst_disp;
        (s_arst_fall ##0 !trip_on) |=> !EXT_ALARM_SHOW && !trip_r;
    endproperty
    a_arst_disp: assert property (p_arst_disp) else $error("reset release did not clear display");

    property p_preset;
        ##1 PRESET_INDEX == {$past(cmd_hit(act, base, CMD_SS4)), $past(cmd_hit(act, base, CMD_SS2)),
                             $past(cmd_hit(act, base, CMD_SS1))};
    endproperty
    a_preset: assert property (p_preset) else $error("preset index wrong");

    property p_polarity;
        (asg_r[0] < NEG_OFFSET && base[0] != CMD_TRIP && base[0] != CMD_STOP) |-> act[0] == deb_r[0];
    endproperty
    a_polarity: assert property (p_polarity) else $error("positive logic terminal inverted");

    property p_bad_write;
        (ack_r && PWRITE && !wr_ok) |=> asg_r[$past(widx)] == $past(asg_r[widx]);
    endproperty
    a_bad_write: assert property (p_bad_write) else $error("refused code was stored");

    property p_two_wire;
        !hold_asg |=> RUN_FWD_CMD == $past(fwd_lvl);
    endproperty
    a_two_wire: assert property (p_two_wire) else $error("two-wire run mismatch");

    property p_hold_keep;
        (hold_on && run_fwd_latch_r) |=> run_fwd_latch_r || !hold_on;
    endproperty
    a_hold_keep: assert property (p_hold_keep) else $error("self-hold lost while held");

    property p_fsel_none;
        (base[0] != CMD_FSEL && base[1] != CMD_FSEL && base[2] != CMD_FSEL && base[3] != CMD_FSEL
         && base[4] != CMD_FSEL && base[5] != CMD_FSEL && base[6] != CMD_FSEL) |=> !FREQ_SOURCE_SEL;
    endproperty
    a_fsel_none: assert property (p_fsel_none) else $error("unassigned select not first source");

    property p_fsel_on;
        cmd_hit(act, base, CMD_FSEL) |=> FREQ_SOURCE_SEL;
    endproperty
    a_fsel_on: assert property (p_fsel_on) else $error("select did not pick second source");

    property p_pump1;
        cmd_hit(act, base, CMD_PUMP1) |=> PUMP_MOTOR_ON[0];
    endproperty
    a_pump1: assert property (p_pump1) else $error("pump one not enabled");

    property p_pclr;
        cmd_hit(act, base, CMD_PCLR) |=> PUMP_TIMER_CLEAR;
    endproperty
    a_pclr: assert property (p_pclr) else $error("pump timer clear missing");

    property p_link;
        cmd_hit(act, base, CMD_LINK) |=> COMMS_LINK_ON;
    endproperty
    a_link: assert property (p_link) else $error("link enable missing");

    property p_stop;
        cmd_hit(act, base, CMD_STOP) |=> FORCE_STOP;
    endproperty
    a_stop: assert property (p_stop) else $error("forced stop missing");

    property p_run_set;
        (cmd_hit(act, base, CMD_RSET) && !hold_asg && !cmd_hit(act, base, CMD_SECOND_SET_FORWARD)) |=> !RUN_FWD_CMD;
    endproperty
    a_run_set: assert property (p_run_set) else $error("first set run leaked through");

    property p_run_place;
        (base[0] != CMD_FWD) && (base[1] != CMD_FWD) && (base[2] != CMD_FWD) && (base[3] != CMD_FWD)
        && (base[4] != CMD_FWD) && (base[0] != CMD_REV) && (base[1] != CMD_REV) && (base[2] != CMD_REV)
        && (base[3] != CMD_REV) && (base[4] != CMD_REV);
    endproperty
    a_run_place: assert property (p_run_place) else $error("run code on general input");

    property p_write_take;
        (ack_r && PWRITE && wr_ok) |=> asg_r[$past(widx)] == $past(wcode);
    endproperty
    a_write_take: assert property (p_write_take) else $error("legal code not stored");

    property p_hold_release;
        !hold_on |=> !run_fwd_latch_r && !run_rev_latch_r;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("self-hold kept after release");

    property p_rev_hold;
        hold_asg |=> RUN_REV_CMD == $past(run_rev_latch_r);
    endproperty
    a_rev_hold: assert property (p_rev_hold) else $error("held reverse run mismatch");

    property p_ready_one;
        (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready not one wait state");
endmodule : pitd_top

// >>> test/pitd_switch_model.sv
`timescale 1ns/1ps
module pitd_switch_model #(
    parameter int HOLD_CYC = 1200,
    parameter int HOLD_IDX = 4
) (
    input  wire logic       clk,
    input  wire logic [6:0] lvl,
    input  wire logic [6:0] glitch,
    output logic      [6:0] term
);
    int unsigned hold_cnt = 0;

    // alarm reset contact stays closed a minimum time once closed
    always_ff @(posedge clk) begin
        if (lvl[HOLD_IDX]) begin
            hold_cnt <= HOLD_CYC;
        end else if (hold_cnt != 0) begin
            hold_cnt <= hold_cnt - 1;
        end
    end

    // contact levels with short bounce laid over them
    assign term = (lvl | (7'(hold_cnt != 0) << HOLD_IDX)) ^ glitch;
endmodule : pitd_switch_model

// >>> test/pitd_top_tb.sv
`timescale 1ns/1ps
module pitd_top_tb;
    import pitd_pkg::*;
    localparam int          HOLD_CYC     = 1200;
    localparam logic [31:0] BAD_CODE [5] = '{32'd1013, 32'd98, 32'd1098, 32'd1099, 32'h0000_0800};
    localparam int          BAD_IDX  [5] = '{0, 0, 5, 6, 2};
    localparam logic [31:0] LVL_CODE [8] = '{32'd24, 32'd50, 32'd51, 32'd52, 32'd53, 32'd54, 32'd87, 32'd1030};
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [7:0]  paddr   = 8'h00;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [6:0]  lvl     = 7'h00;
    logic [6:0]  glitch  = 7'h00;
    logic [31:0] seed    = 32'd10478;
    logic [6:0]  term;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  preset;
    logic        fsel;
    logic [1:0]  run;
    logic [2:0]  trip3;
    logic [7:0]  lvls;
    logic [31:0] rd;
    logic        er;
    logic [6:0]  v;
    int          n_errors    = 0;
    int          check_count = 0;

    always #10 clk_sys = ~clk_sys;

    pitd_switch_model #(.HOLD_CYC(HOLD_CYC), .HOLD_IDX(4)) i_pitd_switch_model (
        .clk(clk_sys), .lvl(lvl), .glitch(glitch), .term(term));

    pitd_top i_pitd_top (
        .CLK_SYS(clk_sys), .RST(rst), .GENERAL_INPUT_1(term[0]), .GENERAL_INPUT_2(term[1]),
        .GENERAL_INPUT_3(term[2]), .GENERAL_INPUT_4(term[3]), .GENERAL_INPUT_5(term[4]),
        .RUN_FORWARD(term[5]), .RUN_BACKWARD(term[6]), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PRESET_INDEX(preset), .FREQ_SOURCE_SEL(fsel), .RUN_FWD_CMD(run[1]), .RUN_REV_CMD(run[0]),
        .OUTPUT_CUT(trip3[0]), .FORCE_STOP(lvls[0]), .FAULT_RELAY(trip3[2]), .EXT_ALARM_SHOW(trip3[1]),
        .PUMP_MOTOR_ON(lvls[5:2]), .PUMP_TIMER_CLEAR(lvls[6]), .RUN_SET_SELECT(lvls[1]),
        .COMMS_LINK_ON(lvls[7]));

    // xorshift source for terminal patterns
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    // expected level outputs for a terminal that is on
    function automatic logic [7:0] exp_lvl(input logic [31:0] c);
        case (c)
            32'd24:   return 8'h80;
            32'd50:   return 8'h40;
            32'd87:   return 8'h02;
            32'd1030: return 8'h01;
            default:  return 8'(1 << (c - 32'd49));
        endcase
    endfunction : exp_lvl

    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_errors++;
            finish_test();
        end
    endtask : apb

    task automatic wr(input int idx, input logic [31:0] code, input logic exp_err);
        apb(1'b1, 8'(4 * idx), code);
        chk("slverr", 32'(er), 32'(exp_err));
    endtask : wr

    task automatic settle();
        repeat (DEB_CYC + 6) @(posedge clk_sys);
    endtask : settle

    task automatic drv(input logic [6:0] nv);
        @(posedge clk_sys);
        lvl <= nv;
        settle();
    endtask : drv

    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        chk("idle", {preset, fsel, run, trip3, lvls}, 32'h0);
        // reset assignments, unmapped read
        for (int i = 0; i < NUM_TERM; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0);
            chk("asg", rd, 32'(ASG_RST[i]));
        end
        apb(1'b0, 8'h20, 32'h0);
        chk("unmapped err", 32'(er), 32'h1);
        // refused codes leave the assignment alone
        for (int i = 0; i < 5; i++) begin
            wr(BAD_IDX[i], BAD_CODE[i], 1'b1);
            apb(1'b0, 8'(4 * BAD_IDX[i]), 32'h0);
            chk("kept", rd, 32'(ASG_RST[BAD_IDX[i]]));
        end
        wr(TERM_FWD, 32'(CMD_FWD), 1'b0);
        // preset index and coast, corners then random
        for (int i = 0; i < 8; i++) begin
            v = (i < 2) ? 7'(7 * i) : 7'(xs() & 32'hF);
            drv(v);
            chk("preset", 32'(preset), 32'(v[2:0]));
            chk("cut", 32'(trip3), {29'h0, 2'b00, v[3]});
        end
        // short bounce is filtered
        drv(7'h00);
        glitch <= 7'h07;
        repeat (DEB_CYC / 2) @(posedge clk_sys);
        glitch <= 7'h00;
        settle();
        chk("bounce", 32'(preset), 32'h0);
        wr(0, 32'd1000, 1'b0);
        settle();
        chk("neg", 32'(preset), 32'h1);
        apb(1'b0, OFS_STATUS, 32'h0);
        chk("status", rd, 32'h0000_0100);
        wr(0, 32'(CMD_SS1), 1'b0);
        // trip both polarities, then alarm reset
        for (int k = 0; k < 2; k++) begin
            drv(k ? 7'h04 : 7'h00);
            wr(2, k ? 32'd9 : 32'd1009, 1'b0);
            drv(k ? 7'h00 : 7'h04);
            chk("trip", 32'(trip3), 32'h7);
            drv(k ? 7'h04 : 7'h00);
            chk("trip held", 32'(trip3), 32'h7);
            drv(lvl | 7'h10);
            chk("arst on", 32'(trip3), 32'h3);
            drv(lvl & 7'h6F);
            repeat (HOLD_CYC) @(posedge clk_sys);
            settle();
            chk("arst off", 32'(trip3), 32'h0);
            wr(2, 32'(CMD_SS4), 1'b0);
        end
        // frequency source
        drv(7'h07);
        chk("fsel none", 32'(fsel), 32'h0);
        wr(0, 32'(CMD_FSEL), 1'b0);
        settle();
        chk("fsel on", 32'(fsel), 32'h1);
        drv(7'h00);
        chk("fsel off", 32'(fsel), 32'h0);
        // two-wire then three-wire run
        drv(7'h20);
        chk("run fwd", 32'(run), 32'h2);
        drv(7'h40);
        chk("run rev", 32'(run), 32'h1);
        wr(1, 32'(CMD_HOLD), 1'b0);
        drv(7'h02);
        drv(7'h22);
        drv(7'h02);
        chk("run held", 32'(run), 32'h2);
        drv(7'h00);
        chk("run free", 32'(run), 32'h0);
        // level commands from table
        for (int i = 0; i < 8; i++) begin
            wr(0, LVL_CODE[i], 1'b0);
            drv(7'h01);
            chk("level on", 32'(lvls), 32'(exp_lvl(LVL_CODE[i])));
            drv(7'h00);
            chk("level off", 32'(lvls), 32'h0);
        end
        // second run set replaces the run terminals
        wr(0, 32'(CMD_RSET), 1'b0);
        wr(1, 32'(CMD_SECOND_SET_FORWARD), 1'b0);
        drv(7'h03);
        chk("run set2 fwd", 32'(run), 32'h2);
        drv(7'h21);
        chk("run set1 masked", 32'(run), 32'h0);
        finish_test();
    end
endmodule : pitd_top_tb
